/* File: inc/hdc_pkg.sv */
// Purpose: constants shared by the health data general command block
// Assumes: one clock, sys_clk at 125 MHz, asynchronous active-high reset
// Notes: byte offsets index the 512-byte health information block
package hdc_pkg;
  localparam int unsigned HDC_BLOCK_BYTES = 512;
  localparam logic [6:0] HDC_IDX_GET = 7'h10;
  localparam logic [6:0] HDC_IDX_PRELOAD = 7'h08;
  localparam int unsigned HDC_DIR_BIT = 0;
  localparam int unsigned HDC_IDX_LSB = 1;
  localparam int unsigned HDC_ARG1_LSB = 8;
  localparam int unsigned HDC_ARG2_LSB = 16;
  localparam int unsigned HDC_ARG3_LSB = 24;
  // byte offsets inside the health block
  localparam int unsigned HDC_OFS_FLASH_IDENT = 0;
  localparam int unsigned HDC_OFS_CTRL_REV = 9;
  localparam int unsigned HDC_OFS_FW_REV = 11;
  localparam int unsigned HDC_OFS_CS_COUNT = 14;
  localparam int unsigned HDC_OFS_BB_MAX = 16;
  localparam int unsigned HDC_OFS_BB_DIE_A = 32;
  localparam int unsigned HDC_OFS_GOOD_RATE = 64;
  localparam int unsigned HDC_OFS_ERASE_TOT = 80;
  localparam int unsigned HDC_OFS_LIFE = 96;
  localparam int unsigned HDC_OFS_ERASE_STAT = 98;
  localparam int unsigned HDC_OFS_POWER_UP = 112;
  localparam int unsigned HDC_OFS_ABN_OFF = 128;
  localparam int unsigned HDC_OFS_MARKER = 176;
  localparam int unsigned HDC_OFS_BB_DIE_B = 184;
  localparam int unsigned HDC_OFS_END = 216;
  localparam int unsigned HDC_DIE_BYTES = 32;
  localparam int unsigned HDC_ERASE_STAT_BYTES = 12;
  localparam logic [8:0] HDC_LAST_BYTE = 9'h1ff;
  typedef enum logic [1:0] {
    HDC_IDLE = 2'b00,
    HDC_SEND = 2'b01
  } hdc_state_type;
endpackage

/* File: core/hdc_decode.sv */
// Purpose: split a general command argument into its fields
// Assumes: argument is stable while cmd_valid is high
// Notes: purely combinational
`timescale 1ns/1ns
module hdc_decode
  import hdc_pkg::*;
(
  input wire logic [31:0] arg,
  output logic read_mode,
  output logic [6:0] func_index,
  output logic [7:0] param1,
  output logic [7:0] param2,
  output logic [7:0] param3,
  output logic is_get,
  output logic is_preload,
  output logic args_zero
);
  // direction, index and parameter fields
  assign read_mode = arg[HDC_DIR_BIT];
  assign func_index = arg[HDC_IDX_LSB +: 7];
  assign param1 = arg[HDC_ARG1_LSB +: 8];
  assign param2 = arg[HDC_ARG2_LSB +: 8];
  assign param3 = arg[HDC_ARG3_LSB +: 8];
  assign is_get = read_mode && (func_index == HDC_IDX_GET);
  assign is_preload = !read_mode && (func_index == HDC_IDX_PRELOAD);
  assign args_zero = (arg[31:8] == 24'h00_0000);
endmodule

/* File: core/hdc_byte_map.sv */
// Purpose: map a byte index of the health block onto captured fields
// Assumes: fields are held stable by the caller during a block
// Notes: unlisted positions read as zero
`timescale 1ns/1ns
module hdc_byte_map
  import hdc_pkg::*;
(
  input wire logic [8:0] idx,
  input wire logic [71:0] flash_identity,
  input wire logic [15:0] controller_revision,
  input wire logic [15:0] firmware_revision,
  input wire logic [7:0] cs_count,
  input wire logic [15:0] bb_replace_max,
  input wire logic [255:0] bb_die_a,
  input wire logic [15:0] good_rate,
  input wire logic [31:0] erase_total,
  input wire logic [15:0] remain_life,
  input wire logic [95:0] erase_stats,
  input wire logic [31:0] power_up_count,
  input wire logic [15:0] abnormal_off_count,
  input wire logic [63:0] product_marker,
  input wire logic [255:0] bb_die_b,
  output logic [7:0] byte_out
);
  // true when idx lies in [base, base+len)
  function automatic logic in_rng(input logic [8:0] i, input int unsigned base, input int unsigned len);
    in_rng = (int'(i) >= base) && (int'(i) < base + len);
  endfunction

  // offset of idx from a field base, cut to nine bits
  function automatic logic [8:0] rel(input logic [8:0] i, input int unsigned base);
    rel = 9'(int'(i) - base);
  endfunction

  // select the byte; lowest byte of each field first
  always_comb begin
    byte_out = 8'h00;
    if (in_rng(idx, HDC_OFS_FLASH_IDENT, 9)) begin
      byte_out = flash_identity[rel(idx, HDC_OFS_FLASH_IDENT)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_CTRL_REV, 2)) begin
      byte_out = controller_revision[rel(idx, HDC_OFS_CTRL_REV)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_FW_REV, 2)) begin
      byte_out = firmware_revision[rel(idx, HDC_OFS_FW_REV)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_CS_COUNT, 1)) begin
      byte_out = cs_count;
    end else if (in_rng(idx, HDC_OFS_BB_MAX, 2)) begin
      byte_out = bb_replace_max[rel(idx, HDC_OFS_BB_MAX)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_BB_DIE_A, HDC_DIE_BYTES)) begin
      byte_out = bb_die_a[rel(idx, HDC_OFS_BB_DIE_A)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_GOOD_RATE, 2)) begin
      byte_out = good_rate[rel(idx, HDC_OFS_GOOD_RATE)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_ERASE_TOT, 4)) begin
      byte_out = erase_total[rel(idx, HDC_OFS_ERASE_TOT)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_LIFE, 2)) begin
      byte_out = remain_life[rel(idx, HDC_OFS_LIFE)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_ERASE_STAT, HDC_ERASE_STAT_BYTES)) begin
      byte_out = erase_stats[rel(idx, HDC_OFS_ERASE_STAT)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_POWER_UP, 4)) begin
      byte_out = power_up_count[rel(idx, HDC_OFS_POWER_UP)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_ABN_OFF, 2)) begin
      byte_out = abnormal_off_count[rel(idx, HDC_OFS_ABN_OFF)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_MARKER, 8)) begin
      byte_out = product_marker[rel(idx, HDC_OFS_MARKER)*8 +: 8];
    end else if (in_rng(idx, HDC_OFS_BB_DIE_B, HDC_DIE_BYTES)) begin
      byte_out = bb_die_b[rel(idx, HDC_OFS_BB_DIE_B)*8 +: 8];
    end
  end
endmodule

/* File: core/hdc_cmd.sv */
// Purpose: card-side general command interpreter for health data
// Assumes: command arrives from logic on sys_clk; data sink is on sys_clk
// Notes: preload snapshots health fields; retrieval streams 512 bytes
// Notes: data_byte trails each stream handshake by one cycle
// Notes: commands are refused, not queued, while a block streams
`timescale 1ns/1ns
module hdc_cmd
  import hdc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_arg,
  output logic cmd_ready,
  output logic cmd_unknown,
  output logic cmd_arg_bad,
  output logic preload_done,
  output logic preloaded,
  output logic [6:0] last_index,
  output logic [7:0] last_param1,
  output logic [7:0] last_param2,
  output logic [7:0] last_param3,
  input wire logic [71:0] flash_identity,
  input wire logic [15:0] controller_revision,
  input wire logic [15:0] firmware_revision,
  input wire logic [7:0] cs_count,
  input wire logic [15:0] bb_replace_max,
  input wire logic [255:0] bb_die_a,
  input wire logic [15:0] good_rate,
  input wire logic [31:0] erase_total,
  input wire logic [15:0] remain_life,
  input wire logic [95:0] erase_stats,
  input wire logic [31:0] power_up_count,
  input wire logic [15:0] abnormal_off_count,
  input wire logic [63:0] product_marker,
  input wire logic [255:0] bb_die_b,
  output logic [7:0] data_byte,
  output logic data_valid,
  output logic data_last,
  input wire logic data_ready
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // fields of the offered argument, meaningful while cmd_valid is high
  logic read_mode;
  logic [6:0] func_index;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] p3;
  logic is_get;
  logic is_preload;
  logic args_zero;
  // block state, index of the byte on offer, accept strobe, mapped byte
  hdc_state_type state_r;
  logic [8:0] idx_r;
  logic take;
  logic [7:0] map_byte;

  // argument decoder: pure field split, holds no state
  hdc_decode u_dec (
    .arg(cmd_arg),
    .read_mode(read_mode),
    .func_index(func_index),
    .param1(p1),
    .param2(p2),
    .param3(p3),
    .is_get(is_get),
    .is_preload(is_preload),
    .args_zero(args_zero)
  );

  // ----------------------------------------------------------------
  // command acceptance
  // ----------------------------------------------------------------
  // commands are accepted only while no block is streaming; a host that
  // offers one mid-block simply waits, since nothing is queued here
  assign cmd_ready = (state_r == HDC_IDLE);
  assign take = cmd_valid && cmd_ready;

  // ----------------------------------------------------------------
  // snapshot of health fields
  // ----------------------------------------------------------------
  // frozen copies of the health inputs, read only by the byte map
  logic [71:0] s_flash_r;
  logic [15:0] s_ctrl_r;
  logic [15:0] s_fw_r;
  logic [7:0] s_cs_r;
  logic [15:0] s_bbmax_r;
  logic [255:0] s_bba_r;
  logic [15:0] s_good_r;
  logic [31:0] s_etot_r;
  logic [15:0] s_life_r;
  logic [95:0] s_estat_r;
  logic [31:0] s_pup_r;
  logic [15:0] s_abn_r;
  logic [63:0] s_mark_r;
  logic [255:0] s_bbb_r;
  logic snap_en;

  // a preload freezes the live values for the retrieval that follows;
  // a retrieval with nothing preloaded freezes them itself at its own
  // take edge, so every block it returns is one consistent picture of
  // the counters even while the live inputs keep moving
  assign snap_en = take && (is_preload || (is_get && !preloaded));

  // preload, or a retrieval with no preload, captures the live values
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_flash_r <= '0;
      s_ctrl_r <= '0;
      s_fw_r <= '0;
      s_cs_r <= '0;
      s_bbmax_r <= '0;
      s_bba_r <= '0;
      s_good_r <= '0;
      s_etot_r <= '0;
      s_life_r <= '0;
      s_estat_r <= '0;
      s_pup_r <= '0;
      s_abn_r <= '0;
      s_mark_r <= '0;
      s_bbb_r <= '0;
    end else if (snap_en) begin
      s_flash_r <= flash_identity;
      s_ctrl_r <= controller_revision;
      s_fw_r <= firmware_revision;
      s_cs_r <= cs_count;
      s_bbmax_r <= bb_replace_max;
      s_bba_r <= bb_die_a;
      s_good_r <= good_rate;
      s_etot_r <= erase_total;
      s_life_r <= remain_life;
      s_estat_r <= erase_stats;
      s_pup_r <= power_up_count;
      s_abn_r <= abnormal_off_count;
      s_mark_r <= product_marker;
      s_bbb_r <= bb_die_b;
    end
  end

  // ----------------------------------------------------------------
  // command status
  // ----------------------------------------------------------------
  // preloaded flag: set by preload, consumed by the retrieval that follows;
  // a second preload only refreshes the snapshot and keeps the flag set,
  // and a retrieval always clears it whether or not a preload came first
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      preloaded <= 1'b0;
    end else if (take && is_preload) begin
      preloaded <= 1'b1;
    end else if (take && is_get) begin
      preloaded <= 1'b0;
    end
  end

  // preload acknowledge: one-cycle pulse, no data follows a preload
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      preload_done <= 1'b0;
    end else begin
      preload_done <= take && is_preload;
    end
  end

  // unknown command: direction and index match neither function
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_unknown <= 1'b0;
    end else begin
      cmd_unknown <= take && !is_preload && !is_get;
    end
  end

  // reserved argument bits set on a known command; the command still runs
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_arg_bad <= 1'b0;
    end else begin
      cmd_arg_bad <= take && (is_get || is_preload) && !args_zero;
    end
  end

  // index of the last accepted command, whatever its function
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_index <= 7'h00;
    end else if (take) begin
      last_index <= func_index;
    end
  end

  // the three parameter bytes of the last accepted command
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_param1 <= 8'h00;
      last_param2 <= 8'h00;
      last_param3 <= 8'h00;
    end else if (take) begin
      last_param1 <= p1;
      last_param2 <= p2;
      last_param3 <= p3;
    end
  end

  // ----------------------------------------------------------------
  // block streaming
  // ----------------------------------------------------------------
  // byte map: picks the byte at idx_r out of the frozen fields
  hdc_byte_map u_map (
    .idx(idx_r),
    .flash_identity(s_flash_r),
    .controller_revision(s_ctrl_r),
    .firmware_revision(s_fw_r),
    .cs_count(s_cs_r),
    .bb_replace_max(s_bbmax_r),
    .bb_die_a(s_bba_r),
    .good_rate(s_good_r),
    .erase_total(s_etot_r),
    .remain_life(s_life_r),
    .erase_stats(s_estat_r),
    .power_up_count(s_pup_r),
    .abnormal_off_count(s_abn_r),
    .product_marker(s_mark_r),
    .bb_die_b(s_bbb_r),
    .byte_out(map_byte)
  );

  // ----------------------------------------------------------------
  // stream timing
  // ----------------------------------------------------------------
  // data_valid rises on the cycle after a retrieval is taken and idx_r
  // then names the byte on offer; a handshake moves idx_r on by one.
  // data_byte is loaded from the map at every edge, so after the edge
  // that takes byte n it holds byte n, one cycle behind the handshake.
  // a sink must therefore sample data_byte on the cycle after each take;
  // this keeps the wide map off the output path at the cost of one
  // cycle of latency on the data.
  // a retrieval with no preload snapshots at its own take edge; byte 0
  // is loaded at the first handshake, which is at least one edge later,
  // so it always sees the fresh snapshot.
  // the index wraps to zero on the last take and is parked there while
  // idle, so the next block always starts at byte 0.
  // data_valid and data_last are combinational from state_r and idx_r.
  // reserved positions come out of the map as zero, so nothing masks here.
  logic byte_take;
  logic last_take;

  // one byte leaves on each handshake; the last one ends the block
  assign byte_take = data_valid && data_ready;
  assign last_take = byte_take && (idx_r == HDC_LAST_BYTE);

  // block state; only a retrieval starts a block
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= HDC_IDLE;
    end else begin
      unique case (state_r)
        HDC_IDLE: begin
          if (take && is_get) begin
            state_r <= HDC_SEND;
          end
        end
        HDC_SEND: begin
          if (last_take) begin
            state_r <= HDC_IDLE;
          end
        end
        default: begin
          state_r <= HDC_IDLE;
        end
      endcase
    end
  end

  // byte index: parked at zero unless streaming, stepped by each handshake
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_r <= 9'h000;
    end else if (state_r != HDC_SEND) begin
      idx_r <= 9'h000;
    end else if (byte_take) begin
      idx_r <= idx_r + 9'h001;                // wraps to zero after the last byte
    end
  end

  // registered data byte, one cycle behind the handshake that takes it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_byte <= 8'h00;
    end else begin
      data_byte <= map_byte;
    end
  end

  // ----------------------------------------------------------------
  // stream handshake outputs
  // ----------------------------------------------------------------
  // valid for the whole block; last marks byte 511 while it is on offer,
  // so the sink sees the end of the block on the handshake itself
  assign data_valid = (state_r == HDC_SEND);
  assign data_last = data_valid && (idx_r == HDC_LAST_BYTE);
endmodule

/* File: tb/hdc_cmd_sva.sv */
// Purpose: port-level checks for the health data command block
// Assumes: one clock domain, reset active high
// Notes: bound onto hdc_cmd from the testbench
`timescale 1ns/1ns
module hdc_cmd_sva
  import hdc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_arg,
  input wire logic cmd_ready,
  input wire logic cmd_unknown,
  input wire logic cmd_arg_bad,
  input wire logic preload_done,
  input wire logic preloaded,
  input wire logic [6:0] last_index,
  input wire logic [7:0] last_param1,
  input wire logic [7:0] last_param2,
  input wire logic [7:0] last_param3,
  input wire logic data_valid,
  input wire logic data_last,
  input wire logic data_ready
);
  logic acc;
  logic [9:0] cnt_r;
  assign acc = cmd_valid && cmd_ready;
  // count bytes taken within a block
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 10'h000;
    end else if (!data_valid) begin
      cnt_r <= 10'h000;
    end else if (data_ready) begin
      cnt_r <= cnt_r + 10'h001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_pre; acc && cmd_arg[7:0] == 8'h10 |=> preload_done && preloaded && !data_valid; endproperty
  a_pre: assert property (p_pre) else $error("preload not acknowledged");
  property p_get; acc && cmd_arg[7:0] == 8'h21 |=> data_valid && !preloaded; endproperty
  a_get: assert property (p_get) else $error("retrieval did not start");
  property p_unk; acc && !(cmd_arg[7:0] inside {8'h10, 8'h21}) |=> cmd_unknown && !data_valid; endproperty
  a_unk: assert property (p_unk) else $error("unknown command not flagged");
  property p_dir; acc && cmd_arg[7:0] == 8'h11 |=> !preload_done; endproperty
  a_dir: assert property (p_dir) else $error("read bit ignored");
  property p_bad; acc && cmd_arg[7:0] inside {8'h10, 8'h21} |=> cmd_arg_bad == ($past(cmd_arg) > 32'h0000_00ff); endproperty
  a_bad: assert property (p_bad) else $error("argument check wrong");
  property p_fld; acc |=> {last_param3, last_param2, last_param1, last_index} == 31'($past(cmd_arg) >> 1); endproperty
  a_fld: assert property (p_fld) else $error("argument fields wrong");
  property p_rdy; data_valid |-> !cmd_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("command taken while streaming");
  property p_hold; data_valid && !data_ready |=> data_valid; endproperty
  a_hold: assert property (p_hold) else $error("stream dropped on stall");
  property p_last; data_valid |-> data_last == (cnt_r == 10'h1ff); endproperty
  a_last: assert property (p_last) else $error("last byte marker wrong");
  property p_end; data_valid && data_ready && data_last |=> !data_valid && cmd_ready; endproperty
  a_end: assert property (p_end) else $error("stream did not end");
  c_pre: cover property (acc && cmd_arg[7:0] == 8'h10);
  c_get: cover property (data_valid && data_ready && data_last);
  c_unk: cover property (cmd_unknown);
endmodule

/* File: tb/hdc_host_model.sv */
// Purpose: host side that offers general commands and sinks the data block
// Assumes: driven just after the rising edge
// Notes: sink stalls one cycle in three when slow is set
`timescale 1ns/1ns
module hdc_host_model (
  input wire logic sys_clk,
  input wire logic cmd_ready,
  input wire logic slow,
  output logic cmd_valid,
  output logic [31:0] cmd_arg,
  output logic data_ready
);
  logic [1:0] ph_r;
  initial begin
    cmd_valid = 1'b0;
    cmd_arg = 32'h0000_0000;
    data_ready = 1'b1;
    ph_r = 2'h0;
  end
  // offer one command and hold it until the edge that takes it
  task automatic send(input logic [31:0] arg);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_arg = arg;
    @(negedge sys_clk);
    while (!cmd_ready) @(negedge sys_clk);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_arg = ~arg; // released lines do not keep the old value
  endtask
  // data sink with optional stalls
  always @(posedge sys_clk) begin
    ph_r <= #1 (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
    data_ready <= #1 !(slow && ph_r == 2'h0);
  end
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the health data command block
// Assumes: host model drives commands, bench drives health values
// Notes: bytes are checked one cycle after each take
`timescale 1ns/1ns
module testbench
  import hdc_pkg::*;
;
  logic sys_clk, sys_rst, slow, inv_x, pend, cmd_valid, cmd_ready, cmd_unknown, cmd_arg_bad;
  logic preload_done, preloaded, data_valid, data_last, data_ready;
  logic [31:0] cmd_arg, erase_total, power_up_count;
  logic [6:0] last_index;
  logic [7:0] last_param1, last_param2, last_param3, cs_count, data_byte;
  logic [71:0] flash_identity;
  logic [15:0] controller_revision, firmware_revision, bb_replace_max, good_rate, remain_life, abnormal_off_count;
  logic [255:0] bb_die_a, bb_die_b;
  logic [95:0] erase_stats;
  logic [63:0] product_marker;
  logic [31:0] tbl [4] = '{32'h0000_0011, 32'h0000_0020, 32'h0000_0003, 32'h3322_1110};
  int err_total = 0, samples_checked = 0, cyc = 0, nb = 0;
  hdc_host_model host (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .slow(slow), .cmd_valid(cmd_valid),
    .cmd_arg(cmd_arg), .data_ready(data_ready));
  hdc_cmd dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_arg(cmd_arg),
    .cmd_ready(cmd_ready), .cmd_unknown(cmd_unknown), .cmd_arg_bad(cmd_arg_bad), .preload_done(preload_done),
    .preloaded(preloaded), .last_index(last_index), .last_param1(last_param1), .last_param2(last_param2),
    .last_param3(last_param3), .flash_identity(flash_identity), .controller_revision(controller_revision),
    .firmware_revision(firmware_revision), .cs_count(cs_count), .bb_replace_max(bb_replace_max),
    .bb_die_a(bb_die_a), .good_rate(good_rate), .erase_total(erase_total), .remain_life(remain_life),
    .erase_stats(erase_stats), .power_up_count(power_up_count), .abnormal_off_count(abnormal_off_count),
    .product_marker(product_marker), .bb_die_b(bb_die_b), .data_byte(data_byte), .data_valid(data_valid),
    .data_last(data_last), .data_ready(data_ready));
  // expected byte of the block; undefined places are zero
  function automatic logic [7:0] eb(input int i, input logic inv);
    if (i inside {[0:12], 14, [16:17], [32:65], [80:83], [96:109], [112:115], [128:129], [176:215]})
      return 8'(i) ^ 8'h5a ^ {8{inv}};
    return 8'h00;
  endfunction
  function automatic logic [255:0] pk(input int o, input int n, input logic inv);
    logic [255:0] v;
    v = '0;
    for (int k = 0; k < n; k++) v[k*8 +: 8] = eb(o + k, inv);
    return v;
  endfunction
  // drive all health fields, little-endian
  task automatic set_health(input logic inv);
    flash_identity = 72'(pk(0, 9, inv));
    controller_revision = 16'(pk(9, 2, inv));
    firmware_revision = 16'(pk(11, 2, inv));
    cs_count = 8'(pk(14, 1, inv));
    bb_replace_max = 16'(pk(16, 2, inv));
    bb_die_a = pk(32, 32, inv);
    good_rate = 16'(pk(64, 2, inv));
    erase_total = 32'(pk(80, 4, inv));
    remain_life = 16'(pk(96, 2, inv));
    erase_stats = 96'(pk(98, 12, inv));
    power_up_count = 32'(pk(112, 4, inv));
    abnormal_off_count = 16'(pk(128, 2, inv));
    product_marker = 64'(pk(176, 8, inv));
    bb_die_b = pk(184, 32, inv);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // retrieval, then wait for the whole block
  task automatic get_block(input logic inv);
    inv_x = inv;
    nb = 0;
    host.send(32'h0000_0021);
    for (int w = 0; w < 2000 && nb < 512; w++) @(posedge sys_clk);
    #1;
    chk(nb, 512, "block length");
    chk(preloaded, 1'b0, "preload consumed");
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // timeout guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      stop_test();
    end
  end
  // byte monitor, one cycle after each take
  always @(negedge sys_clk) begin
    if (pend) begin
      chk(data_byte, eb(nb, inv_x), "block byte");
      nb++;
    end
    pend = data_valid && data_ready;
    if (pend) chk(data_last, nb == 511, "last marker");
  end
  initial begin
    sys_rst = 1'b1;
    slow = 1'b0;
    inv_x = 1'b0;
    pend = 1'b0;
    set_health(1'b0);
    repeat (20) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    chk({cmd_ready, data_valid, preloaded}, 3'h4, "reset state");
    host.send(32'h0000_0010);
    @(negedge sys_clk);
    chk({preload_done, preloaded, data_valid}, 3'h6, "preload result");
    set_health(1'b1);
    slow = 1'b1;
    get_block(1'b0);
    get_block(1'b1);
    slow = 1'b0;
    for (int i = 0; i < 4; i++) begin
      host.send(tbl[i]);
      @(negedge sys_clk);
      chk({cmd_unknown, cmd_arg_bad}, {i < 3, i == 3}, "command flags");
      chk({last_param3, last_param2, last_param1, last_index}, tbl[i][31:1], "fields");
    end
    stop_test();
  end
endmodule
bind hdc_cmd hdc_cmd_sva chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
  .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .cmd_unknown(cmd_unknown), .cmd_arg_bad(cmd_arg_bad),
  .preload_done(preload_done), .preloaded(preloaded), .last_index(last_index), .last_param1(last_param1),
  .last_param2(last_param2), .last_param3(last_param3), .data_valid(data_valid), .data_last(data_last),
  .data_ready(data_ready));
